// file: logic/comparator_event_control.v
// comparator control, event detection, input steering and AHB-Lite registers
//
// Behaviour
// - result reads one when positive exceeds negative
// - raw result synchronised, one to two cycles
// - mode field: toggle, reserved, falling, rising
// - event flag set on matching edge
// - flag cleared by vector or written one
// - request needs flag, enable and global enable
// - power-off bit removes comparator power
// - reference select picks internal reference
// - mux enable, converter off: channel picks negative
// - reserved bit two reads zero
// - input disable forces pin read zero
// - converter on only while enable set
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "comparator_event_control_defines.vh"
module comparator_event_control (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // analog core
   input wire cmpRawOut,
   output wire cmpPowerOff,
   output wire posUseInternalRef,
   output wire [2:0] negInputSelect,
   // pins, raw digital levels and gated port reads
   input wire posPinLevel,
   input wire negPinLevel,
   output wire posPinBufferOn,
   output wire negPinBufferOn,
   output reg posPinRead,
   output reg negPinRead,
   // interrupt system
   input wire vectorTaken,
   output wire cmpIrqRequest,
   output wire irq
);
   // registers
   reg negMuxEnable;
   reg [2:0] triggerSelect;
   reg powerOff;
   reg internalRef;
   reg eventFlag;
   reg irqEnable;
   reg [1:0] eventMode;
   reg [5:0] inputDisable;
   reg converterEnable;
   reg [1:0] channelSelectLow;
   reg globalIrqEnable;
   reg [2:0] irqStatus;
   reg [2:0] irqMask;

   // address phase capture
   reg dataPhase;
   reg dataWrite;
   reg [7:0] dataAddr;

   wire cmpResult;
   wire posPinSync;
   wire negPinSync;
   wire riseEvt;
   wire fallEvt;
   wire toggleEvt;
   reg modeMatch;
   wire [7:0] wbyte;
   wire writeCtrlB;
   wire writeCtrlStatus;
   wire writeDisable;
   wire writeSetup;
   wire writeMask;
   wire writeProc;
   wire readIrqStatus;
   wire flagClearByWrite;
   wire [2:0] irqEvents;
   wire takeTransfer;
   wire clearFlag;

   // read views of the register words
   wire [7:0] ctrlBWord;
   wire [7:0] ctrlStatusWord;
   wire [7:0] disableWord;
   wire [8:0] setupWord;
   wire [7:0] procWord;

   // the raw comparator level is forced low while powered off; it is async
   level_sync syncResult (
      .clock(clock),
      .reset_n(reset_n),
      .asyncIn(cmpRawOut & ~powerOff),
      .syncOut(cmpResult)
   );

   level_sync syncPos (
      .clock(clock),
      .reset_n(reset_n),
      .asyncIn(posPinLevel),
      .syncOut(posPinSync)
   );

   level_sync syncNeg (
      .clock(clock),
      .reset_n(reset_n),
      .asyncIn(negPinLevel),
      .syncOut(negPinSync)
   );

   edge_detect edges (
      .clock(clock),
      .reset_n(reset_n),
      .level(cmpResult),
      .rise(riseEvt),
      .fall(fallEvt),
      .toggle(toggleEvt)
   );

   // mode selection of the event
   always @* begin
      case (eventMode)
         `MODE_TOGGLE: modeMatch = toggleEvt;
         `MODE_FALLING: modeMatch = fallEvt;
         `MODE_RISING: modeMatch = riseEvt;
         default: modeMatch = 1'b0;
      endcase
   end

   // bus write strobes, decoded in the data phase
   assign wbyte = hwdata[7:0];
   assign writeCtrlB = dataPhase & dataWrite & (dataAddr == `OFS_CONVERTER_CONTROL_B);
   assign writeCtrlStatus = dataPhase & dataWrite &
                            (dataAddr == `OFS_COMPARATOR_CONTROL_STATUS);
   assign writeDisable = dataPhase & dataWrite & (dataAddr == `OFS_DIGITAL_INPUT_DISABLE);
   assign writeSetup = dataPhase & dataWrite & (dataAddr == `OFS_CONVERTER_SETUP);
   assign writeMask = dataPhase & dataWrite & (dataAddr == `OFS_IRQ_MASK);
   assign writeProc = dataPhase & dataWrite & (dataAddr == `OFS_PROCESSOR_STATUS);
   assign readIrqStatus = dataPhase & ~dataWrite & (dataAddr == `OFS_IRQ_STATUS);
   assign flagClearByWrite = writeCtrlStatus & wbyte[`BIT_CMP_EVENT_FLAG];
   assign clearFlag = vectorTaken | flagClearByWrite;
   assign takeTransfer = hsel & htrans[1];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dataPhase <= 1'b0;
         dataWrite <= 1'b0;
         dataAddr <= 8'h00;
      end else if (hready) begin
         dataPhase <= takeTransfer;
         dataWrite <= hwrite;
         dataAddr <= haddr[7:0];
      end
   end

   // control registers, one process per register word
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         negMuxEnable <= 1'b0;
         triggerSelect <= 3'h0;
      end else if (writeCtrlB) begin
         negMuxEnable <= wbyte[`BIT_NEG_MUX_ENABLE];
         triggerSelect <= wbyte[2:0];
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         powerOff <= 1'b0;
         internalRef <= 1'b0;
         irqEnable <= 1'b0;
         eventMode <= `MODE_TOGGLE;
      end else if (writeCtrlStatus) begin
         powerOff <= wbyte[`BIT_CMP_POWER_OFF];
         internalRef <= wbyte[`BIT_INTERNAL_REF_SELECT];
         irqEnable <= wbyte[`BIT_CMP_IRQ_ENABLE];
         eventMode <= wbyte[`BIT_EVENT_MODE_HI:`BIT_EVENT_MODE_LO];
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         inputDisable <= 6'h00;
      end else if (writeDisable) begin
         inputDisable <= wbyte[5:0];
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         converterEnable <= 1'b0;
         channelSelectLow <= 2'h0;
      end else if (writeSetup) begin
         converterEnable <= hwdata[`BIT_CONVERTER_ENABLE];
         channelSelectLow <= hwdata[1:0];
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irqMask <= `RESET_IRQ;
      end else if (writeMask) begin
         irqMask <= hwdata[2:0];
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         globalIrqEnable <= 1'b0;
      end else if (writeProc) begin
         globalIrqEnable <= hwdata[`BIT_PROCESSOR_GLOBAL_IRQ];
      end
   end

   // event flag: a matching edge wins over any clear in the same cycle
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         eventFlag <= 1'b0;
      end else if (modeMatch) begin
         eventFlag <= 1'b1;
      end else if (clearFlag) begin
         eventFlag <= 1'b0;
      end
   end

   // sticky status cleared by its read, new events win over the clear
   assign irqEvents = {fallEvt, riseEvt, modeMatch};
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irqStatus <= `RESET_IRQ;
      end else if (readIrqStatus) begin
         irqStatus <= irqEvents;
      end else begin
         irqStatus <= irqStatus | irqEvents;
      end
   end

   assign cmpIrqRequest = eventFlag & irqEnable & globalIrqEnable;
   assign irq = |(irqStatus & irqMask);

   // analog steering
   assign cmpPowerOff = powerOff;
   assign posUseInternalRef = internalRef;
   assign negInputSelect = (negMuxEnable & ~converterEnable) ?
                           {1'b0, channelSelectLow} : `NEG_SEL_PIN;

   // digital input buffers and gated reads
   assign posPinBufferOn = ~inputDisable[`BIT_POS_PIN_INPUT_OFF];
   assign negPinBufferOn = ~inputDisable[`BIT_NEG_PIN_INPUT_OFF];
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         posPinRead <= 1'b0;
         negPinRead <= 1'b0;
      end else begin
         posPinRead <= posPinSync & posPinBufferOn;
         negPinRead <= negPinSync & negPinBufferOn;
      end
   end

   assign ctrlBWord = {1'b0, negMuxEnable, 3'h0, triggerSelect};
   assign ctrlStatusWord = {powerOff, internalRef, cmpResult, eventFlag,
                            irqEnable, 1'b0, eventMode};
   assign disableWord = {2'h0, inputDisable};
   assign setupWord = {converterEnable, 6'h00, channelSelectLow};
   assign procWord = {globalIrqEnable, 7'h00};

   // read data, driven in the data phase from the registers
   always @* begin
      hrdata = 32'h00000000;
      if (dataPhase & ~dataWrite) begin
         if (dataAddr == `OFS_CONVERTER_CONTROL_B) begin
            hrdata[7:0] = ctrlBWord;
         end else if (dataAddr == `OFS_COMPARATOR_CONTROL_STATUS) begin
            hrdata[7:0] = ctrlStatusWord;
         end else if (dataAddr == `OFS_DIGITAL_INPUT_DISABLE) begin
            hrdata[7:0] = disableWord;
         end else if (dataAddr == `OFS_CONVERTER_SETUP) begin
            hrdata[8:0] = setupWord;
         end else if (dataAddr == `OFS_IRQ_STATUS) begin
            hrdata[2:0] = irqStatus;
         end else if (dataAddr == `OFS_IRQ_MASK) begin
            hrdata[2:0] = irqMask;
         end else if (dataAddr == `OFS_PROCESSOR_STATUS) begin
            hrdata[7:0] = procWord;
         end
      end
   end
endmodule // comparator_event_control

// file: logic/comparator_event_control_defines.vh
// register offsets, field positions and reset values of the comparator control block
`ifndef COMPARATOR_EVENT_CONTROL_DEFINES_VH
`define COMPARATOR_EVENT_CONTROL_DEFINES_VH

// byte addresses of the register words
`define OFS_CONVERTER_CONTROL_B 8'h00
`define OFS_COMPARATOR_CONTROL_STATUS 8'h04
`define OFS_DIGITAL_INPUT_DISABLE 8'h08
`define OFS_CONVERTER_SETUP 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_PROCESSOR_STATUS 8'h18

// converter_control_b fields
`define BIT_NEG_MUX_ENABLE 6
`define MASK_CONVERTER_CONTROL_B 8'h47

// comparator_control_status fields
`define BIT_CMP_POWER_OFF 7
`define BIT_INTERNAL_REF_SELECT 6
`define BIT_CMP_RESULT 5
`define BIT_CMP_EVENT_FLAG 4
`define BIT_CMP_IRQ_ENABLE 3
`define BIT_EVENT_MODE_HI 1
`define BIT_EVENT_MODE_LO 0

// event mode encodings
`define MODE_TOGGLE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_FALLING 2'h2
`define MODE_RISING 2'h3

// digital_input_disable fields
`define BIT_POS_PIN_INPUT_OFF 0
`define BIT_NEG_PIN_INPUT_OFF 1
`define MASK_DIGITAL_INPUT_DISABLE 8'h3F

// converter setup word: enable in bit 8, channel select low in bits 1..0; processor status word: global enable in bit 7
`define BIT_CONVERTER_ENABLE 8
`define BIT_PROCESSOR_GLOBAL_IRQ 7

// interrupt status/mask bits
`define IRQ_BIT_EVENT 0
`define IRQ_BIT_RISE 1
`define IRQ_BIT_FALL 2

// reset values
`define RESET_BYTE 8'h00
`define RESET_IRQ 3'h0

// negative input selection codes
`define NEG_SEL_PIN 3'h4

`endif

// file: logic/edge_detect.v
// edge detector producing rise, fall and toggle pulses
`timescale 1ns/1ps
module edge_detect (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // synchronised level and pulses
   input wire level,
   output wire rise,
   output wire fall,
   output wire toggle
);
   reg lastLevel;
   reg primed;

   // no pulse on the first cycle after reset, the history is unknown
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lastLevel <= 1'b0;
         primed <= 1'b0;
      end else begin
         lastLevel <= level;
         primed <= 1'b1;
      end
   end

   assign rise = primed & level & ~lastLevel;
   assign fall = primed & ~level & lastLevel;
   assign toggle = rise | fall;
endmodule // edge_detect

// file: logic/level_sync.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
module level_sync (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // level
   input wire asyncIn,
   output reg syncOut
);
   reg stage1;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule // level_sync

// file: testbench/cmp_core_model.sv
// analog comparator core model with input selection and power
`timescale 1ns/1ps
module cmp_core_model (
   // clock
   input logic clock,
   // controls from the block
   input logic cmpPowerOff,
   input logic posUseInternalRef,
   input logic [2:0] negInputSelect,
   // analog levels in millivolts
   input int posMv,
   input int negMv,
   input int refMv,
   input int chanMv [4],
   // raw output
   output logic cmpRawOut
);
   logic junk = 1'b0;
   int p;
   int n;
   // unpowered output wanders
   always @(posedge clock) junk <= !junk;
   always @* begin
      p = posUseInternalRef ? refMv : posMv;
      n = negInputSelect < 3'h4 ? chanMv[negInputSelect[1:0]] : negMv;
      cmpRawOut = cmpPowerOff ? junk : p > n;
   end
endmodule // cmp_core_model

// file: testbench/cmp_event_props.sv
// checker for the comparator event control block
`timescale 1ns/1ps
module cmp_event_props (
   // clock, reset and bus
   input logic clock,
   input logic reset_n,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   input logic [31:0] hrdata,
   // core, pins and interrupt
   input logic cmpRawOut,
   input logic cmpPowerOff,
   input logic posUseInternalRef,
   input logic [2:0] negInputSelect,
   input logic posPinBufferOn,
   input logic negPinBufferOn,
   input logic posPinRead,
   input logic negPinRead,
   input logic vectorTaken,
   input logic cmpIrqRequest
);
   wire take = hsel && hready && htrans == 2'h2;
   wire wr = take && hwrite;
   wire rd = take && !hwrite;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or error");
   a_read_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_resv_zero: assert property ($past(rd && haddr[7:0] == 8'h04) |-> !hrdata[2])
      else $error("reserved bit reads one");
   a_ref_write: assert property ($changed(posUseInternalRef) |-> $past(wr, 2))
      else $error("reference select moved without write");
   a_off_write: assert property ($changed(cmpPowerOff) |-> $past(wr, 2))
      else $error("power off moved without write");
   a_nsel_write: assert property ($changed(negInputSelect) |-> $past(wr, 2))
      else $error("negative select moved without write");
   a_pos_gated: assert property (!posPinBufferOn && $past(!posPinBufferOn) |-> !posPinRead)
      else $error("positive pin read while buffer off");
   a_neg_gated: assert property (!negPinBufferOn && $past(!negPinBufferOn) |-> !negPinRead)
      else $error("negative pin read while buffer off");
   a_vector_clear: assert property (vectorTaken && $past(cmpRawOut, 2) == $past(cmpRawOut, 3)
      && $past(cmpPowerOff, 2) == $past(cmpPowerOff, 3) |=> !cmpIrqRequest)
      else $error("request stays after vector");
endmodule // cmp_event_props
bind comparator_event_control cmp_event_props u_props (.clock, .reset_n, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .cmpRawOut, .cmpPowerOff,
   .posUseInternalRef, .negInputSelect, .posPinBufferOn, .negPinBufferOn, .posPinRead,
   .negPinRead, .vectorTaken, .cmpIrqRequest);

// file: testbench/testbench.sv
// self-checking bench for the comparator event control block
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic posPinLevel = 1'b0;
   logic negPinLevel = 1'b0;
   logic vectorTaken = 1'b0;
   logic cmpRawOut;
   wire hreadyout, hresp, cmpPowerOff, posUseInternalRef, posPinBufferOn, negPinBufferOn;
   wire posPinRead, negPinRead, cmpIrqRequest, irq;
   wire [31:0] hrdata;
   wire [2:0] negInputSelect;
   int posMv = 100;
   int chanMv [4] = '{10, 20, 30, 40};
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] rdq;
   logic [31:0] r;
   logic [1:0] m;
   logic hit;
   always #12.5 clock = ~clock;
   always @(posedge clock) rdq <= hrdata;
   comparator_event_control DUT (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmpRawOut,
      .cmpPowerOff, .posUseInternalRef, .negInputSelect, .posPinLevel, .negPinLevel,
      .posPinBufferOn, .negPinBufferOn, .posPinRead, .negPinRead, .vectorTaken,
      .cmpIrqRequest, .irq);
   cmp_core_model core (.clock, .cmpPowerOff, .posUseInternalRef, .negInputSelect,
      .posMv, .negMv(200), .refMv(300), .chanMv, .cmpRawOut);
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic go(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clock);
      for (n = 0; hreadyout !== 1'b1 && n < 20; n++) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      for (n = n; hreadyout !== 1'b1 && n < 40; n++) @(posedge clock);
      #1 r = rdq;
      if (n >= 40) begin
         bad_count++;
         summarize();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      go(a, 1'b0, 32'h0);
      chk(r, e);
   endtask
   task automatic quiet();
      repeat (4) @(posedge clock);
      go(8'h04, 1'b1, 32'h10);
      go(8'h10, 1'b0, 32'h0);
   endtask
   task automatic edge_wait(input int v);
      @(posedge clock);
      posMv <= v;
      repeat (4) @(posedge clock);
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      go(8'h20, 1'b1, 32'hFF);
      for (int a = 0; a <= 8'h20; a += 4) rd(a[7:0], 32'h0);
      chk({negInputSelect, posPinBufferOn, negPinBufferOn}, 5'h13);
      $display("reset test done");
      go(8'h00, 1'b1, 32'h47);
      rd(8'h00, 32'h47);
      for (int k = 0; k < 4; k++) begin
         go(8'h0C, 1'b1, k);
         chk(negInputSelect, k);
         go(8'h0C, 1'b1, 32'h100 | k);
         chk(negInputSelect, 3'h4);
      end
      go(8'h0C, 1'b1, 32'h2);
      repeat (4) @(posedge clock);
      rd(8'h04, 32'h30);
      go(8'h00, 1'b1, 32'h0);
      quiet();
      go(8'h04, 1'b1, 32'hC4);
      chk({cmpPowerOff, posUseInternalRef}, 2'h3);
      repeat (4) @(posedge clock);
      rd(8'h04, 32'hC0);
      go(8'h04, 1'b1, 32'h40);
      repeat (4) @(posedge clock);
      rd(8'h04, 32'h70);
      go(8'h04, 1'b1, 32'h0);
      quiet();
      $display("steering test done");
      go(8'h14, 1'b1, 32'h1);
      go(8'h18, 1'b1, 32'h80);
      for (int i = 0; i < 4; i++) begin
         m = i;
         go(8'h04, 1'b1, m);
         go(8'h04, 1'b1, 32'h8 | m);
         hit = m == 2'h0 || m == 2'h3;
         edge_wait(300);
         chk({cmpIrqRequest, irq}, {hit, hit});
         rd(8'h04, {26'h0, 1'b1, hit, 2'h2, m});
         rd(8'h10, {30'h0, 1'b1, hit});
         chk(irq, 1'b0);
         go(8'h04, 1'b1, 32'h18 | m);
         chk(cmpIrqRequest, 1'b0);
         hit = m == 2'h0 || m == 2'h2;
         edge_wait(100);
         chk(cmpIrqRequest, hit);
         vectorTaken <= 1'b1;
         @(posedge clock);
         vectorTaken <= 1'b0;
         #1 chk(cmpIrqRequest, 1'b0);
         rd(8'h10, {29'h0, 1'b1, 1'b0, hit});
         go(8'h04, 1'b1, 32'h0);
      end
      go(8'h14, 1'b1, 32'h0);
      go(8'h18, 1'b1, 32'h0);
      go(8'h04, 1'b1, 32'h8);
      edge_wait(300);
      chk({cmpIrqRequest, irq}, 2'h0);
      rd(8'h10, 32'h3);
      $display("event test done");
      @(posedge clock);
      posPinLevel <= 1'b1;
      negPinLevel <= 1'b1;
      repeat (4) @(posedge clock);
      chk({posPinRead, negPinRead}, 2'h3);
      go(8'h08, 1'b1, 32'h3);
      repeat (2) @(posedge clock);
      chk({posPinRead, negPinRead, posPinBufferOn, negPinBufferOn}, 4'h0);
      rd(8'h08, 32'h3);
      $display("pin test done");
      summarize();
   end
endmodule // testbench
